// [irq_pkg.sv]
// shared constants for the interrupt pending arbiter
package irq_pkg;
    localparam int unsigned num_src = 32;
    localparam int unsigned idx_w = 5;
    // register byte offsets
    localparam logic [7:0] off_source_pending = 8'h00;
    localparam logic [7:0] off_mode_select = 8'h04;
    localparam logic [7:0] off_source_mask = 8'h08;
    localparam logic [7:0] off_winner_pending = 8'h10;
    localparam logic [7:0] off_winner_index = 8'h14;
    // reset values
    localparam logic [31:0] rst_pending = 32'h0000_0000;
    localparam logic [31:0] rst_mode = 32'h0000_0000;
    localparam logic [31:0] rst_mask = 32'hffff_ffff;
    // AXI responses
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    // source input that carries the ORed serial port errors
    localparam int unsigned serial_err_src = 28;
endpackage

// [arb_if.sv]
// carrier between the controller and its priority picker
`timescale 1ns/1ps
interface arb_if;
    logic [31:0] req;
    logic found;
    logic [4:0] index;
    modport picker (input req, output found, output index);
    modport user (output req, input found, input index);
endinterface

// [prio_pick.sv]
// fixed priority picker: lowest set bit wins
`timescale 1ns/1ps
module prio_pick (
    arb_if.picker a
);
    // per bit: win if set and no lower bit set
    logic [31:0] lower;
    genvar g;
    assign lower[0] = 1'b0;
    generate
        for (g = 1; g < 32; g++)
        begin : g_chain
            assign lower[g] = lower[g-1] | a.req[g-1];
        end
    endgenerate
    // encode winner index
    always_comb
    begin
        a.found = |a.req;
        a.index = 5'h00;
        for (int i = 31; i >= 0; i--)
        begin
            if (a.req[i] && !lower[i])
            begin
                a.index = 5'(i);
            end
        end
    end
endmodule

// [interrupt_pending_arbiter.sv]
// interrupt controller: pending latch, mask, fixed priority, fast/normal lines
//
// What this block, the core and software must do
// R1: accept requests from thirty-two sources
// R2: OR both serial error outputs into one
// R3: arbitrate first, then raise the request line
// R4: fixed priority; winner recorded in winner pending
// R5: per source fast or normal selection
// R6: requesting source sets its source pending bit
// R7: at most one winner pending bit set
// R8: masked source sets pending, winner untouched
// R9: both readable; write one clears, zero keeps
// R10: software clears source bit before winner bit
// R11: mask one blocks, mask zero allows
// R12: core ignores line while its disable set
// R13: core serves when winner set, enabled
// R14: line stays high while routed winner set
`timescale 1ns/1ps
module interrupt_pending_arbiter (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // interrupt sources, level high
    input wire logic [31:0] irq_src_i,
    input wire logic [1:0] serial_err_i,
    // requests to the core
    output logic fast_interrupt_request_o,
    output logic normal_interrupt_request_o,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    typedef struct packed {
        logic [31:0] sync1;
        logic [31:0] sync2;
        logic [31:0] sync3;
        logic [31:0] source_pending_bits;
        logic [31:0] winner_pending_bits;
        logic [31:0] source_mask_bits;
        logic [31:0] mode_bits;
        logic [4:0] win_idx;
        logic fast_q;
        logic normal_q;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t s_q;
    state_t s_d;
    arb_if arb ();

    // merged request vector: serial errors share one input
    logic [31:0] raw_req;
    always_comb
    begin
        raw_req = irq_src_i; // R1
        raw_req[irq_pkg::serial_err_src] = serial_err_i[0] | serial_err_i[1]; // R2
    end

    // arbitrate only among pending unmasked sources, and only when no winner is open
    assign arb.req = s_q.source_pending_bits & ~s_q.source_mask_bits; // R11
    prio_pick u_pick (
        .a(arb)
    );

    // bus decode helpers
    logic do_write;
    logic do_read;
    logic [31:0] wmask;
    logic wr_ok;
    // requests seen stable by the synchroniser; shared by the latch and its checks
    logic [31:0] level_ok;
    assign level_ok = s_q.sync2 & s_q.sync3;
    assign do_write = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    assign do_read = s_axi_arvalid_i && !s_q.rvalid;
    assign wmask = {{8{s_q.w_strb[3]}}, {8{s_q.w_strb[2]}}, {8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
    assign wr_ok = (s_q.aw_addr == irq_pkg::off_source_pending) || (s_q.aw_addr == irq_pkg::off_mode_select)
        || (s_q.aw_addr == irq_pkg::off_source_mask) || (s_q.aw_addr == irq_pkg::off_winner_pending);

    // next state
    always_comb
    begin
        logic [31:0] clr_src;
        logic [31:0] clr_win;
        logic [31:0] rise;
        clr_src = 32'h0000_0000;
        clr_win = 32'h0000_0000;
        rise = 32'h0000_0000;
        s_d = s_q;
        // three stage pin synchroniser; a request counts when stages two and three are both high
        s_d.sync1 = raw_req;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        // level sensitive: a source still asserting keeps its pending bit set
        rise = level_ok;
        // write channel capture, either order
        if (s_axi_awvalid_i && !s_q.aw_have)
        begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !s_q.w_have)
        begin
            s_d.w_have = 1'b1;
            s_d.w_data = s_axi_wdata_i;
            s_d.w_strb = s_axi_wstrb_i;
        end
        if (do_write)
        begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = wr_ok ? irq_pkg::resp_okay : irq_pkg::resp_slverr;
            case (s_q.aw_addr)
                irq_pkg::off_source_pending: clr_src = s_q.w_data & wmask; // R9
                irq_pkg::off_winner_pending: clr_win = s_q.w_data & wmask; // R9
                irq_pkg::off_mode_select: s_d.mode_bits = (s_q.mode_bits & ~wmask) | (s_q.w_data & wmask); // R5
                irq_pkg::off_source_mask:
                    s_d.source_mask_bits = (s_q.source_mask_bits & ~wmask) | (s_q.w_data & wmask);
                default: ;
            endcase
        end
        if (s_q.bvalid && s_axi_bready_i)
        begin
            s_d.bvalid = 1'b0;
        end
        // set wins over a clear in the same cycle, masked or not
        s_d.source_pending_bits = (s_q.source_pending_bits & ~clr_src) | rise; // R6 R8
        s_d.winner_pending_bits = s_q.winner_pending_bits & ~clr_win;
        // a new winner is posted only once the previous one is cleared
        if (s_d.winner_pending_bits == 32'h0000_0000 && s_q.winner_pending_bits == 32'h0000_0000 && arb.found)
        begin
            s_d.winner_pending_bits = 32'h0000_0001 << arb.index; // R3 R4 R7
            s_d.win_idx = arb.index;
        end
        // lines follow the routed winner bit
        s_d.fast_q = |(s_d.winner_pending_bits & s_q.mode_bits); // R5 R14
        s_d.normal_q = |(s_d.winner_pending_bits & ~s_q.mode_bits); // R5 R14
        // read channel: one cycle to data
        if (do_read)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp = irq_pkg::resp_okay;
            case (s_axi_araddr_i)
                irq_pkg::off_source_pending: s_d.rdata = s_q.source_pending_bits;
                irq_pkg::off_mode_select: s_d.rdata = s_q.mode_bits;
                irq_pkg::off_source_mask: s_d.rdata = s_q.source_mask_bits;
                irq_pkg::off_winner_pending: s_d.rdata = s_q.winner_pending_bits;
                irq_pkg::off_winner_index: s_d.rdata = {27'h0000000, s_q.win_idx};
                default:
                begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rresp = irq_pkg::resp_slverr;
                end
            endcase
        end
        else if (s_q.rvalid && s_axi_rready_i)
        begin
            s_d.rvalid = 1'b0;
        end
    end

    // register the whole state
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
            s_q.source_pending_bits <= irq_pkg::rst_pending;
            s_q.winner_pending_bits <= irq_pkg::rst_pending;
            s_q.source_mask_bits <= irq_pkg::rst_mask;
            s_q.mode_bits <= irq_pkg::rst_mode;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs
    assign fast_interrupt_request_o = s_q.fast_q;
    assign normal_interrupt_request_o = s_q.normal_q;
    assign s_axi_awready_o = !s_q.aw_have;
    assign s_axi_wready_o = !s_q.w_have;
    assign s_axi_bvalid_o = s_q.bvalid;
    assign s_axi_bresp_o = s_q.bresp;
    assign s_axi_arready_o = !s_q.rvalid;
    assign s_axi_rvalid_o = s_q.rvalid;
    assign s_axi_rdata_o = s_q.rdata;
    assign s_axi_rresp_o = s_q.rresp;

    // at most one winner bit at any time
    a_one_winner: assert property (@(posedge clock_i) disable iff (rst_i) // R7
        $onehot0(s_q.winner_pending_bits))
        else $error("more than one winner pending bit");

    // a stable request reaches source pending within four edges
    a_src_latch: assert property (@(posedge clock_i) disable iff (rst_i) // R6
        (raw_req[0] [*4]) |=> s_q.source_pending_bits[0])
        else $error("source pending not set by request");

    // masked source never becomes the winner
    a_mask_block: assert property (@(posedge clock_i) disable iff (rst_i) // R8
        (s_q.winner_pending_bits == 32'h0000_0000)
        |=> ((s_q.winner_pending_bits & $past(s_q.source_mask_bits)) == 32'h0000_0000))
        else $error("masked source won arbitration");

    // unmasked pending with idle winner yields a winner next edge
    a_win_post: assert property (@(posedge clock_i) disable iff (rst_i) // R3 R11
        (arb.found && s_q.winner_pending_bits == 32'h0000_0000) |=> (s_q.winner_pending_bits != 32'h0000_0000))
        else $error("no winner posted");

    // lowest candidate wins
    a_fixed_prio: assert property (@(posedge clock_i) disable iff (rst_i) // R4
        (arb.found && s_q.winner_pending_bits == 32'h0000_0000 && arb.req[0])
        |=> s_q.winner_pending_bits[0] && s_q.win_idx == 5'h00)
        else $error("priority order broken");

    // fast line routed by mode
    a_fast_line: assert property (@(posedge clock_i) disable iff (rst_i) // R5 R14
        (|(s_q.winner_pending_bits & s_q.mode_bits)) && $stable(s_q.winner_pending_bits) && $stable(s_q.mode_bits)
        |-> fast_interrupt_request_o)
        else $error("fast line low with fast winner");

    // normal line routed by mode
    a_norm_line: assert property (@(posedge clock_i) disable iff (rst_i) // R5 R14
        (|(s_q.winner_pending_bits & ~s_q.mode_bits)) && $stable(s_q.winner_pending_bits) && $stable(s_q.mode_bits)
        |-> normal_interrupt_request_o)
        else $error("normal line low with normal winner");

    // write one clears source bit unless source still requesting
    sequence clr_src_write;
        do_write && s_q.aw_addr == irq_pkg::off_source_pending && s_q.w_data[1] && s_q.w_strb[0];
    endsequence
    a_clear_src: assert property (@(posedge clock_i) disable iff (rst_i) // R9
        clr_src_write ##0 !(s_q.sync2[1] & s_q.sync3[1]) |=> !s_q.source_pending_bits[1])
        else $error("write one did not clear source bit");

    // write response stands until the master takes it
    a_bvalid_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        (s_q.bvalid && !s_axi_bready_i) |=> (s_q.bvalid && $stable(s_q.bresp)))
        else $error("write response dropped early");

    // read data stand until the master takes them
    a_rvalid_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        (s_q.rvalid && !s_axi_rready_i) |=> (s_q.rvalid && $stable(s_q.rdata) && $stable(s_q.rresp)))
        else $error("read data dropped early");

    // a taken read is answered on the next edge
    a_read_answer: assert property (@(posedge clock_i) disable iff (rst_i)
        do_read |=> s_q.rvalid)
        else $error("read not answered");

    // an executed write is answered on the next edge
    a_write_answer: assert property (@(posedge clock_i) disable iff (rst_i)
        do_write |=> s_q.bvalid)
        else $error("write not answered");

    // reads past the map are refused with zero data
    a_read_refuse: assert property (@(posedge clock_i) disable iff (rst_i)
        (do_read && s_axi_araddr_i > irq_pkg::off_winner_index)
        |=> (s_q.rresp == irq_pkg::resp_slverr && s_q.rdata == 32'h0000_0000))
        else $error("unmapped read not refused");

    // the recorded index names the open winner bit
    a_win_index: assert property (@(posedge clock_i) disable iff (rst_i) // R4
        (s_q.winner_pending_bits != 32'h0000_0000) |-> s_q.winner_pending_bits[s_q.win_idx])
        else $error("winner index does not match winner bit");

    // no winner, no request line
    a_lines_idle: assert property (@(posedge clock_i) disable iff (rst_i) // R14
        (s_q.winner_pending_bits == 32'h0000_0000) |-> (!fast_interrupt_request_o && !normal_interrupt_request_o))
        else $error("request line high without winner");

    // one winner means one line at a time
    a_one_line: assert property (@(posedge clock_i) disable iff (rst_i) // R5 R7
        !(fast_interrupt_request_o && normal_interrupt_request_o))
        else $error("both request lines high");

    // either serial error raises the shared source
    a_serial_merge: assert property (@(posedge clock_i) disable iff (rst_i) // R2
        (serial_err_i != 2'h0) |-> raw_req[irq_pkg::serial_err_src])
        else $error("serial error not merged");

    // a stable request sets its pending bit, masked or not
    a_pend_set: assert property (@(posedge clock_i) disable iff (rst_i) // R6 R8
        (level_ok != 32'h0000_0000) |=> ((s_q.source_pending_bits & $past(level_ok)) == $past(level_ok)))
        else $error("stable request not latched");

    // source pending bits fall only through a write to their register
    a_pend_keep: assert property (@(posedge clock_i) disable iff (rst_i) // R6 R9
        !(do_write && s_q.aw_addr == irq_pkg::off_source_pending)
        |=> (($past(s_q.source_pending_bits) & ~s_q.source_pending_bits) == 32'h0000_0000))
        else $error("source pending bit lost");

    // winner bits fall only through a write to their register
    a_win_keep: assert property (@(posedge clock_i) disable iff (rst_i) // R9
        !(do_write && s_q.aw_addr == irq_pkg::off_winner_pending)
        |=> (($past(s_q.winner_pending_bits) & ~s_q.winner_pending_bits) == 32'h0000_0000))
        else $error("winner pending bit lost");

    // full word writes to the configuration registers
    sequence mask_write;
        do_write && s_q.aw_addr == irq_pkg::off_source_mask && s_q.w_strb == 4'hf;
    endsequence
    sequence mode_write;
        do_write && s_q.aw_addr == irq_pkg::off_mode_select && s_q.w_strb == 4'hf;
    endsequence

    // mask word lands as written
    a_mask_write: assert property (@(posedge clock_i) disable iff (rst_i) // R11
        mask_write |=> (s_q.source_mask_bits == $past(s_q.w_data)))
        else $error("mask write lost");

    // mode word lands as written
    a_mode_write: assert property (@(posedge clock_i) disable iff (rst_i) // R5
        mode_write |=> (s_q.mode_bits == $past(s_q.w_data)))
        else $error("mode write lost");
endmodule

// [core_model.sv]
// processor core model: takes fast and normal requests unless disabled
`timescale 1ns/1ps
module core_model (
    // request lines from the controller
    input wire logic fast_req_i,
    input wire logic normal_req_i,
    // disable flags of the core status word
    input wire logic fast_off_i,
    input wire logic normal_off_i,
    // service started
    output logic fast_serve_o,
    output logic normal_serve_o
);
    // level inputs, so a request held across a disabled spell is not lost
    assign fast_serve_o = fast_req_i & !fast_off_i;
    assign normal_serve_o = normal_req_i & !normal_off_i;
endmodule

// [interrupt_pending_arbiter_test.sv]
// self-checking bench for the interrupt pending arbiter
`timescale 1ns/1ps
module interrupt_pending_arbiter_test;
    typedef struct packed {logic [4:0] src; logic ser; logic fast; logic msk;} row_t;
    logic clock_i, rst_i, awv, wv, bready, arv, rready, f_off, n_off;
    logic [31:0] src, wdata, bit_v, rd;
    logic [7:0] awaddr, araddr;
    logic [1:0] serr, rs;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic fast_req, normal_req, awrdy, wrdy, bvld, arrdy, rvld, fast_serve, normal_serve;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    // source, via serial error, fast mode, masked
    row_t rows [6] = '{'{5'h00, 1'b0, 1'b0, 1'b0}, '{5'h05, 1'b0, 1'b1, 1'b0},
        '{5'h1f, 1'b0, 1'b0, 1'b0}, '{5'h1c, 1'b1, 1'b1, 1'b0}, '{5'h07, 1'b0, 1'b0, 1'b1},
        '{5'h01, 1'b0, 1'b0, 1'b0}};

    interrupt_pending_arbiter dut (.clock_i(clock_i), .rst_i(rst_i), .irq_src_i(src), .serial_err_i(serr),
        .fast_interrupt_request_o(fast_req), .normal_interrupt_request_o(normal_req),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvld), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arrdy), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvld),
        .s_axi_rready_i(rready));
    core_model core (.fast_req_i(fast_req), .normal_req_i(normal_req), .fast_off_i(f_off),
        .normal_off_i(n_off), .fast_serve_o(fast_serve), .normal_serve_o(normal_serve));

    // 25 MHz clock
    always #20 clock_i = ~clock_i;

    // hang guard; the whole run needs well under this
    always @(posedge clock_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clock_i);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clock_i);
            if (awv && awrdy)
                awv <= 1'b0;
            if (wv && wrdy)
                wv <= 1'b0;
        end while (!bvld);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock_i);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clock_i);
            if (arv && arrdy)
                arv <= 1'b0;
        end while (!rvld);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // hold the request well past the synchroniser, then let it settle through arbitration
    task automatic pulse(input logic [31:0] s, input logic [1:0] e);
        @(posedge clock_i);
        src <= s;
        serr <= e;
        repeat (6) @(posedge clock_i);
        src <= 32'h0;
        serr <= 2'h0;
        repeat (8) @(posedge clock_i);
    endtask

    task automatic stop_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // main sequence: reset values first, then table rows, priority, refusals, mid-run reset
    initial
    begin
        {clock_i, awv, wv, bready, arv, rready, f_off, n_off} = 8'h00;
        rst_i = 1'b1;
        {src, wdata, awaddr, araddr, serr} = 82'h0;
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        axi_read(irq_pkg::off_source_mask, rd, rs);
        check("mask_reset", rd, irq_pkg::rst_mask);
        axi_read(irq_pkg::off_mode_select, rd, rs);
        check("mode_reset", rd, irq_pkg::rst_mode);
        for (int i = 0; i < 6; i++)
        begin
            bit_v = 32'h1 << rows[i].src;
            axi_write(irq_pkg::off_mode_select, rows[i].fast ? bit_v : 32'h0, rs);
            axi_write(irq_pkg::off_source_mask, rows[i].msk ? 32'hffff_ffff : ~bit_v, rs);
            pulse(rows[i].ser ? 32'h0 : bit_v, {rows[i].ser, 1'b0});
            axi_read(irq_pkg::off_source_pending, rd, rs);
            check("src_pend", rd, bit_v);
            axi_read(irq_pkg::off_winner_pending, rd, rs);
            check("win_pend", rd, rows[i].msk ? 32'h0 : bit_v);
            check("fast_line", fast_req, rows[i].fast & !rows[i].msk);
            check("norm_line", normal_req, !rows[i].fast & !rows[i].msk);
            check("serve", {fast_serve, normal_serve}, {rows[i].fast & !rows[i].msk, !rows[i].fast & !rows[i].msk});
            axi_read(irq_pkg::off_winner_index, rd, rs);
            if (!rows[i].msk)
                check("win_index", rd, {27'h0, rows[i].src});
            axi_write(irq_pkg::off_source_pending, bit_v, rs);
            check("line_held", fast_req | normal_req, !rows[i].msk);
            axi_write(irq_pkg::off_winner_pending, bit_v, rs);
            repeat (3) @(posedge clock_i);
            check("lines_off", {fast_req, normal_req}, 32'h0);
            axi_read(irq_pkg::off_winner_pending, rd, rs);
            check("win_clear", rd, 32'h0);
        end
        // two at once: lowest index first, the other follows once cleared
        n_off <= 1'b1;
        axi_write(irq_pkg::off_mode_select, 32'h0, rs);
        axi_write(irq_pkg::off_source_mask, ~32'h0000_0208, rs);
        pulse(32'h0000_0208, 2'h0);
        axi_read(irq_pkg::off_winner_pending, rd, rs);
        check("win_first", rd, 32'h0000_0008);
        check("serve_off", {normal_req, normal_serve}, 32'h2);
        axi_write(irq_pkg::off_source_pending, 32'h0, rs);
        axi_read(irq_pkg::off_source_pending, rd, rs);
        check("zero_keeps", rd, 32'h0000_0208);
        axi_write(irq_pkg::off_source_pending, 32'h0000_0008, rs);
        axi_write(irq_pkg::off_winner_pending, 32'h0000_0008, rs);
        repeat (4) @(posedge clock_i);
        axi_read(irq_pkg::off_winner_pending, rd, rs);
        check("win_next", rd, 32'h0000_0200);
        // unmapped place refused both ways
        axi_write(8'h0c, 32'hffff_ffff, rs);
        check("wr_unmapped", rs, irq_pkg::resp_slverr);
        axi_read(8'h0c, rd, rs);
        check("rd_unmapped", rd, 32'h0);
        check("rd_unmapped_resp", rs, irq_pkg::resp_slverr);
        // reset in mid-run with a winner open: all back to reset values
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        check("rst_lines", {fast_req, normal_req}, 32'h0);
        check("rst_bus", {awrdy, wrdy, arrdy, bvld, rvld}, 32'h1c);
        rst_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        check("rel_lines", {fast_req, normal_req}, 32'h0);
        axi_read(irq_pkg::off_source_pending, rd, rs);
        check("rst_src", rd, irq_pkg::rst_pending);
        check("rd_okay", rs, irq_pkg::resp_okay);
        axi_read(irq_pkg::off_winner_pending, rd, rs);
        check("rst_win", rd, irq_pkg::rst_pending);
        axi_read(irq_pkg::off_source_mask, rd, rs);
        check("rst_mask", rd, irq_pkg::rst_mask);
        stop_test();
    end
endmodule
